// ### common/hpsb_pkg.sv
package hpsb_pkg;
   localparam int          NUM_PORTS      = 4;
   localparam int          SYNC_STAGES    = 2;
   // synchronisers start at the pins' idle levels so no false edge follows reset
   localparam logic [6:0]  SYNC_RST       = 7'h63;
   // reset values and power-on level of the pin drivers
   localparam logic        PWR_OFF_N      = 1'b1;
   localparam logic        PWR_ON_N       = 1'b0;
   localparam logic        LED_OFF        = 1'b0;
   localparam logic [3:0]  LED_RST        = 4'h0;
   localparam logic        CORE_ON_N      = 1'b1;
   // debug two-wire shift width
   localparam int          DBG_BITS       = 8;
   localparam logic [7:0]  DBG_RST        = 8'h00;
   // debug command codes (first byte)
   localparam logic [7:0]  DBG_CMD_STAT   = 8'h01;
   localparam logic [7:0]  DBG_CMD_PWRDN  = 8'h02;
   localparam logic [7:0]  DBG_CMD_PWRUP  = 8'h03;

   typedef struct packed {
      logic [3:0] connect;
      logic [3:0] overcurrent;
   } hpsb_led_t;

   typedef struct packed {
      logic serial_out;
      logic serial_clock;
      logic select_n;
   } hpsb_flash_t;
endpackage : hpsb_pkg

// ### design/hpsb_sideband.sv
`timescale 1ns/1ns
// Function
// R1: each port's overcurrent led is high while its overcurrent indication is active
// R2: each port's connect led is high while that port is connected
// R3: overcurrent leds 1..4 double as flash out, in, clock, select; led 2 is only released, flash_serial_in_o stays low
// R4: ganged power enable driven low for power on, high for off
// R5: charge port has its own active-low power enable, independent of gang
// R6: low on an overcurrent input means overcurrent, high means normal
// R7: upstream bus sense is sampled to detect host plug-in
// R8: bus supply presence input is sampled separately
// R9: active-low core power-down output for an external core switch
// R10: test strap low is normal, high is test; board leaves it open
// R11: debug two-wire port with open-drain clock input and data line
// R12: during reset power enables are off and all leds low
module hpsb_sideband (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // core status
   input  wire logic [3:0]  port_connected_i,
   input  wire logic        gang_power_req_i,
   input  wire logic        charge_power_req_i,
   input  wire logic        flash_mode_i,
   input  wire hpsb_pkg::hpsb_flash_t flash_i,
   // pins
   input  wire logic        overcurrent_in_a_n_i,
   input  wire logic        overcurrent_in_b_n_i,
   input  wire logic        upstream_bus_power_sense_i,
   input  wire logic        bus_supply_present_i,
   input  wire logic        test_mode_strap_i,
   input  wire logic        debug_wire_clock_i,
   input  wire logic        debug_wire_data_i,
   // pin outputs
   output logic [3:0]       overcurrent_led_o,
   output logic             overcurrent_led2_oe_o,
   output logic [3:0]       connect_led_o,
   output logic             gang_power_enable_n_o,
   output logic             charge_port_power_enable_n_o,
   output logic             core_supply_off_n_o,
   output logic             debug_wire_data_o,
   output logic             debug_wire_data_oe_o,
   // status to core
   output logic             flash_serial_in_o,
   output logic             host_attached_o,
   output logic             bus_supply_ok_o,
   output logic             test_mode_o
);
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic [3:0] oc_r;
   logic       dclk_d_r;
   logic [7:0] dshift_r;
   logic [2:0] dcnt_r;
   logic [7:0] dstat_r;
   logic       core_dn_r;
   logic       dreply_r;

   function automatic logic [7:0] status_byte(input logic [3:0] oc, input logic h,
                                             input logic b);
      status_byte = {1'b0, b, h, 1'b0, oc};
   endfunction : status_byte

   // two flops on every pin input before any logic reads them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= hpsb_pkg::SYNC_RST;
         sync2_r <= hpsb_pkg::SYNC_RST;
      end else begin
         sync1_r <= {debug_wire_data_i, debug_wire_clock_i, test_mode_strap_i,
                     bus_supply_present_i, upstream_bus_power_sense_i,
                     overcurrent_in_b_n_i, overcurrent_in_a_n_i};
         sync2_r <= sync1_r;
      end
   end

   // input a covers the ganged ports 1,3,4; input b the charge port 2
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oc_r <= 4'h0;
      end else begin
         oc_r <= {~sync2_r[0], ~sync2_r[0], ~sync2_r[1], ~sync2_r[0]}; // [R6]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overcurrent_led_o     <= hpsb_pkg::LED_RST; // [R12]
         overcurrent_led2_oe_o <= 1'b1;
         connect_led_o         <= hpsb_pkg::LED_RST; // [R12]
         flash_serial_in_o     <= 1'b0;
      end else begin
         connect_led_o <= port_connected_i; // [R2]
         if (flash_mode_i) begin
            // port 2 pin turns into an input while flash owns the pins
            overcurrent_led_o     <= {flash_i.select_n, flash_i.serial_clock,
                                      1'b0, flash_i.serial_out}; // [R3]
            overcurrent_led2_oe_o <= 1'b0; // [R3]
         end else begin
            overcurrent_led_o     <= oc_r; // [R1]
            overcurrent_led2_oe_o <= 1'b1;
         end
         flash_serial_in_o <= 1'b0;
      end
   end

   // power is cut while the matching overcurrent is reported
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gang_power_enable_n_o        <= hpsb_pkg::PWR_OFF_N; // [R12]
         charge_port_power_enable_n_o <= hpsb_pkg::PWR_OFF_N; // [R12]
      end else begin
         gang_power_enable_n_o <= (gang_power_req_i && !oc_r[0])
                                  ? hpsb_pkg::PWR_ON_N : hpsb_pkg::PWR_OFF_N; // [R4]
         charge_port_power_enable_n_o <= (charge_power_req_i && !oc_r[1])
                                  ? hpsb_pkg::PWR_ON_N : hpsb_pkg::PWR_OFF_N; // [R5]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_attached_o <= 1'b0;
         bus_supply_ok_o <= 1'b0;
         test_mode_o     <= 1'b0;
      end else begin
         host_attached_o <= sync2_r[2]; // [R7]
         bus_supply_ok_o <= sync2_r[3]; // [R8]
         test_mode_o     <= sync2_r[4]; // [R10]
      end
   end

   // debug port: msb-first byte on rising clock, reply byte shifted on falling
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dclk_d_r             <= 1'b1;
         dshift_r             <= hpsb_pkg::DBG_RST;
         dcnt_r               <= 3'h0;
         dstat_r              <= hpsb_pkg::DBG_RST;
         core_dn_r            <= 1'b0;
         dreply_r             <= 1'b0;
         core_supply_off_n_o  <= hpsb_pkg::CORE_ON_N;
         debug_wire_data_o    <= 1'b0;
         debug_wire_data_oe_o <= 1'b0;
      end else begin
         dclk_d_r <= sync2_r[5];
         if (sync2_r[5] && !dclk_d_r) begin // [R11]
            dshift_r <= {dshift_r[6:0], sync2_r[6]};
            dcnt_r   <= dcnt_r + 3'h1;
            if (dcnt_r == 3'h7) begin
               if (dreply_r) begin
                  // reply byte done: release the line, ignore what was shifted in
                  dreply_r             <= 1'b0;
                  debug_wire_data_oe_o <= 1'b0; // [R11]
               end else begin
                  unique case ({dshift_r[6:0], sync2_r[6]})
                     hpsb_pkg::DBG_CMD_STAT: begin
                        dstat_r  <= status_byte(oc_r, host_attached_o, bus_supply_ok_o);
                        dreply_r <= 1'b1;
                     end
                     hpsb_pkg::DBG_CMD_PWRDN: core_dn_r <= 1'b1;
                     hpsb_pkg::DBG_CMD_PWRUP: core_dn_r <= 1'b0;
                     default:                 dstat_r <= dstat_r;
                  endcase
               end
            end
         end else if (!sync2_r[5] && dclk_d_r && dreply_r) begin
            // only drive during a reply so a command byte is never pulled low
            // open drain: only ever pull low, release for a one
            debug_wire_data_oe_o <= ~dstat_r[3'h7 - dcnt_r]; // [R11]
         end
         core_supply_off_n_o <= ~core_dn_r; // [R9]
      end
   end
endmodule : hpsb_sideband

// ### testbench/hpsb_sideband_chk.sv
`timescale 1ns/1ns
module hpsb_sideband_chk (
   input wire logic clk_i, rst_n_i, flash_mode_i, debug_wire_data_o,
   input wire logic overcurrent_in_a_n_i, overcurrent_in_b_n_i, upstream_bus_power_sense_i,
   input wire logic bus_supply_present_i, test_mode_strap_i, gang_power_req_i,
   input wire logic gang_power_enable_n_o, charge_port_power_enable_n_o, overcurrent_led2_oe_o,
   input wire logic host_attached_o, bus_supply_ok_o, test_mode_o,
   input wire logic [3:0] port_connected_i, overcurrent_led_o, connect_led_o,
   input wire hpsb_pkg::hpsb_flash_t flash_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   rst_hold_a: assert property (disable iff (1'b0) !rst_n_i |->
      gang_power_enable_n_o && charge_port_power_enable_n_o && overcurrent_led_o == 4'h0 &&
      connect_led_o == 4'h0) else $error("output active in reset");
   conn_led_a: assert property ($past(rst_n_i) |->
      connect_led_o == $past(port_connected_i)) else $error("connect led wrong");
   oc_a_led_a: assert property ((!flash_mode_i && $stable(overcurrent_in_a_n_i)) [*5] |->
      {overcurrent_led_o[3:2], overcurrent_led_o[0]} == {3{!overcurrent_in_a_n_i}})
      else $error("overcurrent led a wrong");
   oc_b_led_a: assert property ((!flash_mode_i && $stable(overcurrent_in_b_n_i)) [*5] |->
      overcurrent_led2_oe_o && overcurrent_led_o[1] == !overcurrent_in_b_n_i)
      else $error("overcurrent led b wrong");
   flash_map_a: assert property ((flash_mode_i && $stable(flash_i)) [*3] |->
      !overcurrent_led2_oe_o && overcurrent_led_o == {flash_i.select_n,
      flash_i.serial_clock, 1'b0, flash_i.serial_out}) else $error("flash pins wrong");
   pwr_off_a: assert property (!overcurrent_in_a_n_i [*5] |->
      gang_power_enable_n_o) else $error("gang power on during fault");
   pwr_noreq_a: assert property ($past(!gang_power_req_i) |->
      gang_power_enable_n_o) else $error("gang power on without request");
   chg_off_a: assert property (!overcurrent_in_b_n_i [*5] |->
      charge_port_power_enable_n_o) else $error("charge power on during fault");
   sense_sync_a: assert property ($past(rst_n_i, 3) |->
      {host_attached_o, bus_supply_ok_o, test_mode_o} == $past({upstream_bus_power_sense_i,
      bus_supply_present_i, test_mode_strap_i}, 3)) else $error("sense output wrong");
   dbg_od_a: assert property (debug_wire_data_o == 1'b0)
      else $error("debug data driven high");
endmodule : hpsb_sideband_chk
bind hpsb_sideband hpsb_sideband_chk i_chk (.*);

// ### testbench/hpsb_far_side.sv
`timescale 1ns/1ns
module hpsb_far_side (
   // faults commanded by the bench
   input  wire logic fault_a_i,
   input  wire logic fault_b_i,
   // switch flags, pulled up, low on fault
   output logic      oc_a_n_o,
   output logic      oc_b_n_o
);
   assign oc_a_n_o = !fault_a_i;
   assign oc_b_n_o = !fault_b_i;
endmodule : hpsb_far_side

// ### testbench/hpsb_sideband_test.sv
`timescale 1ns/1ns
module hpsb_sideband_test;
   logic clk_i = 1'b0, rst_n_i = 1'b1, greq = 1'b0, creq = 1'b0, fm = 1'b0, fa = 1'b0;
   logic [7:0] rd;
   logic fb = 1'b0, ups = 1'b0, bus = 1'b0, strap = 1'b0, dclk = 1'b1, ddrv = 1'b1;
   logic oc_a, oc_b, oe2, gn, cn, core, dout, doe, fsi, host, bok, tm;
   logic [3:0] conn = 4'h0, ocl, cled;
   hpsb_pkg::hpsb_flash_t fl = 3'h0;
   logic [14:0] q[$];
   int n_errors = 0, num_checks = 0;
   event probe;
   wire logic dwire = ddrv & !doe; // pulled up, any party may pull low
   always #50 clk_i = !clk_i;
   hpsb_far_side i_far (.fault_a_i(fa), .fault_b_i(fb), .oc_a_n_o(oc_a), .oc_b_n_o(oc_b));
   hpsb_sideband i_dut (.clk_i, .rst_n_i, .port_connected_i(conn), .gang_power_req_i(greq),
      .charge_power_req_i(creq), .flash_mode_i(fm), .flash_i(fl), .overcurrent_in_a_n_i(oc_a),
      .overcurrent_in_b_n_i(oc_b), .upstream_bus_power_sense_i(ups), .bus_supply_present_i(bus),
      .test_mode_strap_i(strap), .debug_wire_clock_i(dclk), .debug_wire_data_i(dwire),
      .overcurrent_led_o(ocl), .overcurrent_led2_oe_o(oe2), .connect_led_o(cled),
      .gang_power_enable_n_o(gn), .charge_port_power_enable_n_o(cn), .core_supply_off_n_o(core),
      .debug_wire_data_o(dout), .debug_wire_data_oe_o(doe), .flash_serial_in_o(fsi),
      .host_attached_o(host), .bus_supply_ok_o(bok), .test_mode_o(tm));
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : idle
   task automatic note(input logic [14:0] e);
      q.push_back(e);
      ->probe;
   endtask : note
   function automatic logic [14:0] full(input logic c);
      return {fa, fa, fb, fa, 1'b1, conn, !(greq && !fa), !(creq && !fb), c, ups, bus, strap};
   endfunction : full
   task automatic cmp(input logic [14:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   always @(probe) cmp(q.pop_front(), {ocl, oe2, cled, gn, cn, core, host, bok, tm});
   task automatic dbg_send(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         dclk = 1'b0;
         ddrv = b[k];
         idle(4);
         dclk = 1'b1;
         idle(4);
      end
      ddrv = 1'b1;
      idle(6);
   endtask : dbg_send
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      summarize();
   end
   initial begin
      void'($urandom(32'hc581ca12));
      #10 rst_n_i = 1'b0;
      idle(2);
      note(15'h0438);
      rst_n_i = 1'b1;
      for (int i = 0; i < 24; i++) begin
         {conn, greq, creq, ups, bus, strap} = 9'($urandom);
         {fa, fb} = ($urandom_range(3) == 0) ? 2'($urandom) : 2'b00;
         idle(6);
         note(full(1'b1));
      end
      $display("test random done");
      fm = 1'b1;
      for (int i = 0; i < 8; i++) begin
         fl = 3'(i);
         idle(4);
         note({fl.select_n, fl.serial_clock, 1'b0, fl.serial_out, 1'b0, full(1'b1)[9:0]});
      end
      fm = 1'b0;
      $display("test flash done");
      dbg_send(hpsb_pkg::DBG_CMD_PWRDN);
      note(full(1'b0));
      dbg_send(hpsb_pkg::DBG_CMD_PWRUP);
      note(full(1'b1));
      dbg_send(hpsb_pkg::DBG_CMD_STAT);
      for (int k = 7; k >= 0; k--) begin
         dclk = 1'b0;
         idle(4);
         rd[k] = dwire;
         dclk = 1'b1;
         idle(4);
      end
      idle(4);
      cmp({7'h0, 1'b0, bus, ups, 1'b0, fa, fa, fb, fa}, {7'h0, rd});
      cmp(15'h0000, {14'h0, doe});
      $display("test debug done");
      rst_n_i = 1'b0;
      idle(1);
      note(15'h0438);
      $display("test reset done");
      summarize();
   end
endmodule : hpsb_sideband_test
